// File: dv/icw_host.sv
// Purpose: AXI4-Lite host model that programs the control block.
// Assumes: Each task is entered just after a rising edge of CLK.
// Notes: Byte address is four times the register index.
`timescale 1ns/100ps
`include "icw_cfg.svh"
module icw_host (
  // Clock.
  input  wire logic        CLK,
  // Write channels.
  output logic [15:0]      AWADDR,
  output logic             AWVALID,
  input  wire logic        AWREADY,
  output logic [31:0]      WDATA,
  output logic [3:0]       WSTRB,
  output logic             WVALID,
  input  wire logic        WREADY,
  input  wire logic [1:0]  BRESP,
  input  wire logic        BVALID,
  output logic             BREADY,
  // Read channels.
  output logic [15:0]      ARADDR,
  output logic             ARVALID,
  input  wire logic        ARREADY,
  input  wire logic [31:0] RDATA,
  input  wire logic [1:0]  RRESP,
  input  wire logic        RVALID,
  output logic             RREADY
);
  initial
  begin
    {AWADDR, AWVALID, WDATA, WVALID, BREADY} = '0;
    {ARADDR, ARVALID, RREADY} = '0;
    WSTRB = 4'h1;
  end
  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [13:0] i, input logic [7:0] d,
                    output logic [1:0] r);
    AWADDR  <= {i, 2'b00};
    WDATA   <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    r = BRESP;
  endtask : wr
  task automatic rd(input logic [13:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    ARADDR  <= {i, 2'b00};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
  endtask : rd
  task automatic upd;
    logic [1:0] r;
    wr(`ICW_IDX_UPDATE, `ICW_UPDATE_KEY, r);
  endtask : upd
endmodule : icw_host

// File: dv/test_irq_watchdog_system_clock_multiplier_control.sv
// Purpose: Self-checking bench for the control and status block.
// Assumes: MS_CYCLES is 8, so one millisecond is eight cycles.
// Notes: Pin and pulse checks sample outputs on the falling edge to avoid races; the event counters sample on the rising edge.
`timescale 1ns/100ps
`include "icw_cfg.svh"
module test_irq_watchdog_system_clock_multiplier_control;
  logic            CLK;
  logic            SYS_RST;
  logic            lock;
  logic [4:0][7:0] evt;
  logic [15:0]     awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, stable, scal, lcal;
  logic [4:0]      mf_out, mf_oe;
  int              err_count = 0, num_checks = 0;
  int              cyc = 0, wcnt = 0, scnt = 0, lcnt = 0;
  icw_top #(.MS_CYCLES(8)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SYSTEM_CLOCK_MULTIPLIER_LOCKED(lock),
    .EVT_IN(evt), .MF_OUT(mf_out), .MF_OE(mf_oe), .SYSTEM_CLOCK_MULTIPLIER_STABLE(stable),
    .SYSTEM_CLOCK_MULTIPLIER_CAL_START(scal), .LOOPS_CAL_START(lcal));
  icw_host host_u (.CLK(CLK), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // The ceiling is several times the expected run length.
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (mf_out[4] === 1'b1) wcnt <= wcnt + 1;
    if (scal === 1'b1) scnt <= scnt + 1;
    if (lcal === 1'b1) lcnt <= lcnt + 1;
    if (cyc == 4000)
    begin
      err_count++;
      print_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [13:0] i, input logic [31:0] e,
                       input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(i, d, r);
    chk(nm, e, d);
    chk("rresp", 32'(`ICW_RESP_OKAY), 32'(r));
  endtask : rdchk
  task automatic wrw(input logic [13:0] i, input logic [7:0] d);
    logic [1:0] r;
    host_u.wr(i, d, r);
    chk("bresp", 32'(`ICW_RESP_OKAY), 32'(r));
  endtask : wrw
  task automatic pulse(input int g, input int b);
    evt[g][b] <= 1'b1;
    @(posedge CLK);
    evt[g][b] <= 1'b0;
    @(posedge CLK);
  endtask : pulse
  task automatic pins(input logic [4:0] oe, input logic [4:0] out);
    repeat (3) @(negedge CLK);
    chk("mf_oe", 32'(oe), 32'(mf_oe));
    chk("mf_out", 32'(out), 32'(mf_out & mf_oe));
    @(posedge CLK);
  endtask : pins
  // Waits for a watchdog pin pulse and checks that it lasts one cycle.
  task automatic wp(output int t);
    int n;
    n = 0;
    @(negedge CLK);
    while (mf_out[4] !== 1'b1 && n < 100)
    begin
      @(negedge CLK);
      n++;
    end
    chk("wd pulse seen", 32'h1, 32'(n < 100));
    t = cyc;
    @(negedge CLK);
    chk("pulse width", 32'h0, 32'(mf_out[4]));
  endtask : wp
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    for (int g = 0; g < 5; g++)
      rdchk(14'(`ICW_IDX_MASK0 + g), 32'h0, "mask");
    rdchk(`ICW_IDX_WD_LO, 32'h0, "wd_lo");
    rdchk(`ICW_IDX_WD_HI, 32'h0, "wd_hi");
    rdchk(`ICW_IDX_STAB, 32'h32, "stab");
    rdchk(`ICW_IDX_PIN0, 32'h0, "pin0");
    host_u.rd(14'h3FFF, d, r);
    chk("unmapped rd", {30'h0, `ICW_RESP_SLVERR}, {d[29:0], r});
    host_u.wr(14'h3FFF, 8'hFF, r);
    chk("unmapped wr", 32'(`ICW_RESP_SLVERR), 32'(r));
    $display("test reset ended");
  endtask : t_reset
  task automatic t_irq;
    wrw(`ICW_IDX_MASK0 + 14'h1, 8'h01);
    wrw(`ICW_IDX_MASK0 + 14'h4, 8'h80);
    host_u.upd;
    pulse(1, 0);
    pulse(1, 1);
    pulse(4, 7);
    rdchk(`ICW_IDX_MON0 + 14'h1, 32'h01, "mon1");
    rdchk(`ICW_IDX_MON0 + 14'h4, 32'h80, "mon4");
    wrw(`ICW_IDX_CLR0 + 14'h1, 8'h01);
    rdchk(`ICW_IDX_MON0 + 14'h1, 32'h0, "mon1 clr");
    rdchk(`ICW_IDX_MON0 + 14'h4, 32'h80, "mon4 kept");
    pulse(1, 0);
    wrw(`ICW_IDX_CLR_ALL, 8'h01);
    rdchk(`ICW_IDX_MON0 + 14'h1, 32'h0, "mon1 all");
    rdchk(`ICW_IDX_MON0 + 14'h4, 32'h0, "mon4 all");
    $display("test irq ended");
  endtask : t_irq
  task automatic t_pins;
    wrw(`ICW_IDX_PIN0, 8'h0A);
    wrw(`ICW_IDX_PIN0 + 14'h1, 8'h1E);
    wrw(`ICW_IDX_PIN0 + 14'h2, 8'h05);
    wrw(`ICW_IDX_PIN0 + 14'h3, 8'h12);
    host_u.upd;
    pulse(1, 0);
    pins(5'b01111, 5'b01000);
    wrw(`ICW_IDX_CLR_ALL, 8'h01);
    pins(5'b00101, 5'b00001);
    pulse(4, 7);
    pins(5'b00111, 5'b00101);
    wrw(`ICW_IDX_CLR_ALL, 8'h01);
    $display("test pins ended");
  endtask : t_pins
  task automatic t_wdog;
    int t1, t2, t3, n0;
    wrw(`ICW_IDX_PIN0 + 14'h4, 8'h07);
    wrw(`ICW_IDX_MASK0, 8'h01);
    wrw(`ICW_IDX_WD_LO, 8'h01);
    host_u.upd;
    wp(t1);
    wp(t2);
    chk("wd period", 32'd8, 32'(t2 - t1));
    @(posedge CLK);
    wrw(`ICW_IDX_CLR_ALL, 8'h80);
    wp(t3);
    chk("restart", 32'h1, 32'(t3 - t2 > 8));
    @(posedge CLK);
    rdchk(`ICW_IDX_MON0, 32'h01, "mon0 wd");
    wrw(`ICW_IDX_WD_LO, 8'h00);
    host_u.upd;
    n0 = wcnt;
    repeat (20) @(posedge CLK);
    chk("wd off", 32'(n0), 32'(wcnt));
    $display("test watchdog ended");
  endtask : t_wdog
  task automatic t_stab;
    int n;
    lock <= 1'b0;
    repeat (2) @(negedge CLK);
    chk("stable low", 32'h0, 32'(stable));
    @(posedge CLK);
    rdchk(`ICW_IDX_MON0, 32'h0, "mon0 unlocked");
    rdchk(`ICW_IDX_STATUS, 32'h0, "status low");
    lock <= 1'b1;
    n = 0;
    while (stable !== 1'b1 && n < 1000)
    begin
      @(posedge CLK);
      n++;
    end
    chk("stab time", 32'h1, 32'(n >= 400 && n <= 404));
    rdchk(`ICW_IDX_STATUS, 32'h03, "status");
    $display("test stability ended");
  endtask : t_stab
  task automatic t_cal;
    int s0, l0;
    s0 = scnt;
    l0 = lcnt;
    wrw(`ICW_IDX_CTRL, 8'h04);
    repeat (3) @(posedge CLK);
    chk("cal early", 32'(s0), 32'(scnt));
    host_u.upd;
    repeat (3) @(posedge CLK);
    chk("sys cal", 32'(s0 + 1), 32'(scnt));
    wrw(`ICW_IDX_CTRL, 8'h06);
    host_u.upd;
    repeat (6) @(posedge CLK);
    chk("loop cal", 32'(l0 + 1), 32'(lcnt));
    $display("test calibration ended");
  endtask : t_cal
  initial
  begin
    SYS_RST = 1'b1;
    lock = 1'b1;
    evt = '0;
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_reset;
    t_irq;
    t_pins;
    t_wdog;
    t_stab;
    t_cal;
    print_verdict;
  end
endmodule : test_irq_watchdog_system_clock_multiplier_control

// File: src/icw_cfg.svh
// Purpose: Register indices, field positions, reset values and timing counts.
// Assumes: Register indices are word indices; byte address is index times 4.
// Notes: Contract
`ifndef ICW_CFG_SVH
`define ICW_CFG_SVH
`define ICW_IDX_UPDATE   14'h000F
`define ICW_IDX_PIN0     14'h0100
`define ICW_IDX_WD_LO    14'h010D
`define ICW_IDX_WD_HI    14'h010E
`define ICW_IDX_MASK0    14'h010F
`define ICW_IDX_STAB     14'h0206
`define ICW_IDX_CTRL     14'h0A00
`define ICW_IDX_CLR_ALL  14'h0A05
`define ICW_IDX_CLR0     14'h0A06
`define ICW_IDX_STATUS   14'h0D01
`define ICW_IDX_MON0     14'h0D08
`define ICW_GROUPS       5
`define ICW_PINS         5
`define ICW_SLOTS        14
`define ICW_SLOT_PIN0    4'h0
`define ICW_SLOT_WD_LO   4'h5
`define ICW_SLOT_WD_HI   4'h6
`define ICW_SLOT_MASK0   4'h7
`define ICW_SLOT_STAB    4'hC
`define ICW_SLOT_CTRL    4'hD
`define ICW_UPDATE_KEY   8'h01
`define ICW_CLR_ALL_BIT  0
`define ICW_CLR_WD_BIT   7
`define ICW_CALALL_BIT   1
`define ICW_CALSYS_BIT   2
`define ICW_STAT_LOCK    0
`define ICW_STAT_STABLE  1
`define ICW_EVT_WD       0
`define ICW_EVT_STABLE   1
`define ICW_EVT_UNLOCK   2
`define ICW_STAB_RST     8'h32
`define ICW_CLK_NS       100
`define ICW_MS_NS        1000000
`define ICW_WD_PULSE_NS  40
`define ICW_RESP_OKAY    2'b00
`define ICW_RESP_SLVERR  2'b10
`endif

// File: src/icw_pkg.sv
// Purpose: Types shared by the control and status block.
// Assumes: Pin configuration byte layout is fixed by icw_pincfg_s.
// Notes: None.
package icw_pkg;
  typedef enum logic [1:0] {
    ICW_DRV_AH  = 2'b00,
    ICW_DRV_AL  = 2'b01,
    ICW_DRV_ODP = 2'b10,
    ICW_DRV_ODN = 2'b11
  } icw_drive_e;
  typedef enum logic [2:0] {
    ICW_FN_NONE  = 3'b000,
    ICW_FN_G0    = 3'b001,
    ICW_FN_G1    = 3'b010,
    ICW_FN_G2    = 3'b011,
    ICW_FN_G3    = 3'b100,
    ICW_FN_G4    = 3'b101,
    ICW_FN_ALL   = 3'b110,
    ICW_FN_WDOG  = 3'b111
  } icw_func_e;
  typedef struct packed {
    logic [2:0] rsvd;
    icw_drive_e drive;
    icw_func_e  func;
  } icw_pincfg_s;
  typedef struct packed {
    logic       hit;
    logic [3:0] slot;
  } icw_slot_s;
  typedef enum logic [1:0] {
    ICW_CAL_IDLE = 2'b00,
    ICW_CAL_WAIT = 2'b01,
    ICW_CAL_FIRE = 2'b10
  } icw_cal_e;
endpackage : icw_pkg

// File: src/icw_top.sv
// Purpose: Interrupt capture, pin routing, watchdog, clock stability and
//          calibration arming behind an AXI4-Lite register slave.
// Assumes: All inputs synchronous to CLK; writes act on byte lane 0 only.
// Notes: Settings are staged and become active on the update strobe.
`timescale 1ns/100ps
`include "icw_cfg.svh"
module icw_top #(
  parameter int MS_CYCLES = `ICW_MS_NS / `ICW_CLK_NS
) (
  // Clock and reset.
  input  wire logic                     CLK,
  input  wire logic                     SYS_RST,
  // AXI4-Lite write channels.
  input  wire logic [15:0]              S_AXI_AWADDR,
  input  wire logic                     S_AXI_AWVALID,
  output logic                          S_AXI_AWREADY,
  input  wire logic [31:0]              S_AXI_WDATA,
  input  wire logic [3:0]               S_AXI_WSTRB,
  input  wire logic                     S_AXI_WVALID,
  output logic                          S_AXI_WREADY,
  output logic [1:0]                    S_AXI_BRESP,
  output logic                          S_AXI_BVALID,
  input  wire logic                     S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [15:0]              S_AXI_ARADDR,
  input  wire logic                     S_AXI_ARVALID,
  output logic                          S_AXI_ARREADY,
  output logic [31:0]                   S_AXI_RDATA,
  output logic [1:0]                    S_AXI_RRESP,
  output logic                          S_AXI_RVALID,
  input  wire logic                     S_AXI_RREADY,
  // Clock multiplier and event sources.
  input  wire logic                     SYSTEM_CLOCK_MULTIPLIER_LOCKED,
  input  wire logic [4:0][7:0]          EVT_IN,
  // Multifunction pins.
  output logic [`ICW_PINS-1:0]          MF_OUT,
  output logic [`ICW_PINS-1:0]          MF_OE,
  // Clock status and calibration starts.
  output logic                          SYSTEM_CLOCK_MULTIPLIER_STABLE,
  output logic                          SYSTEM_CLOCK_MULTIPLIER_CAL_START,
  output logic                          LOOPS_CAL_START
);
  localparam int WD_PULSE_CYC_I =
    (`ICW_WD_PULSE_NS + `ICW_CLK_NS - 1) / `ICW_CLK_NS;
  localparam int WD_PULSE_CYC = (WD_PULSE_CYC_I < 1) ? 1 : WD_PULSE_CYC_I;

  function automatic icw_pkg::icw_slot_s slot_of(input logic [13:0] idx);
    icw_pkg::icw_slot_s s;
    s.hit  = 1'b1;
    s.slot = 4'h0;
    if (idx >= `ICW_IDX_PIN0 && idx < `ICW_IDX_PIN0 + 14'(`ICW_PINS))
      s.slot = 4'(idx - `ICW_IDX_PIN0);
    else if (idx >= `ICW_IDX_WD_LO
             && idx < `ICW_IDX_MASK0 + 14'(`ICW_GROUPS))
      s.slot = 4'(idx - `ICW_IDX_WD_LO) + `ICW_SLOT_WD_LO;
    else if (idx == `ICW_IDX_STAB)
      s.slot = `ICW_SLOT_STAB;
    else if (idx == `ICW_IDX_CTRL)
      s.slot = `ICW_SLOT_CTRL;
    else
      s.hit = 1'b0;
    return s;
  endfunction : slot_of

  logic [`ICW_SLOTS-1:0][7:0]  stg_r;
  logic [`ICW_SLOTS-1:0][7:0]  act_r;
  logic [4:0][7:0]             mon_r;
  logic [4:0][7:0]             mask_w;
  logic [4:0][7:0]             evt_w;
  logic [4:0][7:0]             clr_w;
  logic                        aw_held_r;
  logic                        w_held_r;
  logic [13:0]                 aw_idx_r;
  logic [7:0]                  wdat_r;
  logic                        wlane_r;
  logic                        wr_go;
  logic                        upd_r;
  logic                        clr_all_w;
  logic                        wd_restart_w;
  logic [31:0]                 rd_data;
  logic                        rd_err;
  logic [13:0]                 ar_idx;
  icw_pkg::icw_slot_s          wslot;
  icw_pkg::icw_slot_s          rslot;
  logic [15:0]                 wd_period;
  logic [$clog2(MS_CYCLES)-1:0] wd_pre_r;
  logic [15:0]                 wd_ms_r;
  logic                        wd_exp_r;
  logic [3:0]                  wd_pulse_cnt_r;
  logic                        wd_pulse_r;
  logic [$clog2(MS_CYCLES)-1:0] st_pre_r;
  logic [7:0]                  st_ms_r;
  logic                        locked_q_r;
  logic                        stable_q_r;
  icw_pkg::icw_cal_e           cal_r;
  logic                        irq_any;

  // Write channel: address and data are taken in either order.
  assign wslot = slot_of(aw_idx_r);
  assign wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_idx_r      <= 14'h0000;
      wdat_r        <= 8'h00;
      wlane_r       <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ICW_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held_r     <= 1'b1;
        aw_idx_r      <= S_AXI_AWADDR[15:2];
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held_r     <= 1'b1;
        wdat_r       <= S_AXI_WDATA[7:0];
        wlane_r      <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wslot.hit || aw_idx_r == `ICW_IDX_UPDATE
                         || (aw_idx_r >= `ICW_IDX_CLR_ALL
                             && aw_idx_r < `ICW_IDX_CLR0
                                           + 14'(`ICW_GROUPS)))
                        ? `ICW_RESP_OKAY : `ICW_RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Staged copies take host writes; the active copies change only on update.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      stg_r                 <= '0;
      stg_r[`ICW_SLOT_STAB] <= `ICW_STAB_RST;
      upd_r                 <= 1'b0;
    end
    else
    begin
      if (wr_go && wlane_r && wslot.hit)
        stg_r[wslot.slot] <= wdat_r;
      upd_r <= wr_go && wlane_r && aw_idx_r == `ICW_IDX_UPDATE
               && wdat_r == `ICW_UPDATE_KEY;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      act_r                 <= '0;
      act_r[`ICW_SLOT_STAB] <= `ICW_STAB_RST;
    end
    else if (upd_r)
      act_r <= stg_r;
  end

  // Clearing strobes act at once; they are not staged.
  assign clr_all_w    = wr_go && wlane_r && aw_idx_r == `ICW_IDX_CLR_ALL
                        && wdat_r[`ICW_CLR_ALL_BIT];
  assign wd_restart_w = wr_go && wlane_r && aw_idx_r == `ICW_IDX_CLR_ALL
                        && wdat_r[`ICW_CLR_WD_BIT];

  // Group 0 is the common group; its low bits come from internal events.
  generate
    for (genvar g = 0; g < `ICW_GROUPS; g++)
    begin : g_grp
      assign mask_w[g] = act_r[`ICW_SLOT_MASK0 + 4'(g)];
      assign clr_w[g]  = (wr_go && wlane_r
                          && aw_idx_r == `ICW_IDX_CLR0 + 14'(g))
                         ? wdat_r : 8'h00;
      if (g == 0)
      begin : g_common
        assign evt_w[g] = {EVT_IN[g][7:3],
                           locked_q_r && !SYSTEM_CLOCK_MULTIPLIER_LOCKED,
                           SYSTEM_CLOCK_MULTIPLIER_STABLE && !stable_q_r,
                           wd_exp_r};
      end
      else
      begin : g_loop
        assign evt_w[g] = EVT_IN[g];
      end
    end
  endgenerate

  // A new event wins over a clear arriving in the same cycle.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      mon_r <= '0;
    else if (clr_all_w)
      mon_r <= evt_w & mask_w;
    else
      mon_r <= (mon_r & ~clr_w) | (evt_w & mask_w);
  end

  // Read channel answers one cycle after the address is taken.
  assign ar_idx = S_AXI_ARADDR[15:2];
  assign rslot  = slot_of(ar_idx);

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rslot.hit)
      rd_data[7:0] = stg_r[rslot.slot];
    else if (ar_idx == `ICW_IDX_STATUS)
    begin
      rd_data[`ICW_STAT_LOCK]   = SYSTEM_CLOCK_MULTIPLIER_LOCKED;
      rd_data[`ICW_STAT_STABLE] = SYSTEM_CLOCK_MULTIPLIER_STABLE;
    end
    else if (ar_idx >= `ICW_IDX_MON0
             && ar_idx < `ICW_IDX_MON0 + 14'(`ICW_GROUPS))
    begin
      // Monitor words are only meaningful while the multiplier is locked.
      if (SYSTEM_CLOCK_MULTIPLIER_LOCKED)
        rd_data[7:0] = mon_r[3'(ar_idx - `ICW_IDX_MON0)];
    end
    else if (!(ar_idx == `ICW_IDX_UPDATE
               || (ar_idx >= `ICW_IDX_CLR_ALL
                   && ar_idx < `ICW_IDX_CLR0 + 14'(`ICW_GROUPS))))
      rd_err = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `ICW_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_data;
      S_AXI_RRESP   <= rd_err ? `ICW_RESP_SLVERR : `ICW_RESP_OKAY;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

  // Watchdog counts whole milliseconds; a zero period keeps it disabled.
  assign wd_period = {act_r[`ICW_SLOT_WD_HI], act_r[`ICW_SLOT_WD_LO]};

  always_ff @(posedge CLK)
  begin
    if (SYS_RST || wd_restart_w || wd_period == 16'h0000)
    begin
      wd_pre_r <= '0;
      wd_ms_r  <= 16'h0000;
      wd_exp_r <= 1'b0;
    end
    else
    begin
      wd_exp_r <= 1'b0;
      if (wd_pre_r == $bits(wd_pre_r)'(MS_CYCLES - 1))
      begin
        wd_pre_r <= '0;
        if (wd_ms_r == wd_period - 16'h0001)
        begin
          wd_ms_r  <= 16'h0000;
          wd_exp_r <= 1'b1;
        end
        else
          wd_ms_r <= wd_ms_r + 16'h0001;
      end
      else
        wd_pre_r <= wd_pre_r + 1'b1;
    end
  end

  // The pulse is stretched to the shortest whole number of clock periods.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wd_pulse_cnt_r <= 4'h0;
      wd_pulse_r     <= 1'b0;
    end
    else if (wd_exp_r)
    begin
      wd_pulse_cnt_r <= 4'(WD_PULSE_CYC - 1);
      wd_pulse_r     <= 1'b1;
    end
    else if (wd_pulse_cnt_r != 4'h0)
      wd_pulse_cnt_r <= wd_pulse_cnt_r - 4'h1;
    else
      wd_pulse_r <= 1'b0;
  end

  // Stability: lock must hold for the programmed number of milliseconds.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || !SYSTEM_CLOCK_MULTIPLIER_LOCKED)
    begin
      st_pre_r      <= '0;
      st_ms_r       <= 8'h00;
      SYSTEM_CLOCK_MULTIPLIER_STABLE <= 1'b0;
    end
    else if (!SYSTEM_CLOCK_MULTIPLIER_STABLE)
    begin
      if (st_ms_r >= act_r[`ICW_SLOT_STAB])
        SYSTEM_CLOCK_MULTIPLIER_STABLE <= 1'b1;
      else if (st_pre_r == $bits(st_pre_r)'(MS_CYCLES - 1))
      begin
        st_pre_r <= '0;
        st_ms_r  <= st_ms_r + 8'h01;
      end
      else
        st_pre_r <= st_pre_r + 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      locked_q_r <= 1'b0;
      stable_q_r <= 1'b0;
    end
    else
    begin
      locked_q_r <= SYSTEM_CLOCK_MULTIPLIER_LOCKED;
      stable_q_r <= SYSTEM_CLOCK_MULTIPLIER_STABLE;
    end
  end

  // Calibration: loop calibration is held back until the clock is stable.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cal_r            <= icw_pkg::ICW_CAL_IDLE;
      SYSTEM_CLOCK_MULTIPLIER_CAL_START <= 1'b0;
      LOOPS_CAL_START  <= 1'b0;
    end
    else
    begin
      SYSTEM_CLOCK_MULTIPLIER_CAL_START <= upd_r
        && ((stg_r[`ICW_SLOT_CTRL][`ICW_CALSYS_BIT]
             && !act_r[`ICW_SLOT_CTRL][`ICW_CALSYS_BIT])
            || stg_r[`ICW_SLOT_CTRL][`ICW_CALALL_BIT]);
      LOOPS_CAL_START  <= 1'b0;
      case (cal_r)
        icw_pkg::ICW_CAL_IDLE:
          if (upd_r && stg_r[`ICW_SLOT_CTRL][`ICW_CALALL_BIT])
            cal_r <= icw_pkg::ICW_CAL_WAIT;
        icw_pkg::ICW_CAL_WAIT:
          if (SYSTEM_CLOCK_MULTIPLIER_STABLE)
            cal_r <= icw_pkg::ICW_CAL_FIRE;
        icw_pkg::ICW_CAL_FIRE:
        begin
          LOOPS_CAL_START <= SYSTEM_CLOCK_MULTIPLIER_STABLE;
          cal_r <= SYSTEM_CLOCK_MULTIPLIER_STABLE ? icw_pkg::ICW_CAL_IDLE
                                 : icw_pkg::ICW_CAL_WAIT;
        end
        default:
          cal_r <= icw_pkg::ICW_CAL_IDLE;
      endcase
    end
  end

  // Pin routing and drive style; unassigned pins stay undriven.
  assign irq_any = |mon_r;

  generate
    for (genvar p = 0; p < `ICW_PINS; p++)
    begin : g_pin
      icw_pkg::icw_pincfg_s cfg;
      logic                 act;
      assign cfg = icw_pkg::icw_pincfg_s'(act_r[`ICW_SLOT_PIN0 + 4'(p)]);
      always_comb
      begin
        case (cfg.func)
          icw_pkg::ICW_FN_G0:   act = |mon_r[0];
          icw_pkg::ICW_FN_G1:   act = |mon_r[1];
          icw_pkg::ICW_FN_G2:   act = |mon_r[2];
          icw_pkg::ICW_FN_G3:   act = |mon_r[3];
          icw_pkg::ICW_FN_G4:   act = |mon_r[4];
          icw_pkg::ICW_FN_ALL:  act = irq_any;
          icw_pkg::ICW_FN_WDOG: act = wd_pulse_r;
          default:              act = 1'b0;
        endcase
      end
      always_ff @(posedge CLK)
      begin
        if (SYS_RST || cfg.func == icw_pkg::ICW_FN_NONE)
        begin
          MF_OUT[p] <= 1'b0;
          MF_OE[p]  <= 1'b0;
        end
        else
        begin
          case (cfg.drive)
            icw_pkg::ICW_DRV_AL:  {MF_OUT[p], MF_OE[p]} <= {!act, 1'b1};
            icw_pkg::ICW_DRV_ODP: {MF_OUT[p], MF_OE[p]} <= {1'b1, act};
            icw_pkg::ICW_DRV_ODN: {MF_OUT[p], MF_OE[p]} <= {1'b0, act};
            default:              {MF_OUT[p], MF_OE[p]} <= {act, 1'b1};
          endcase
        end
      end
    end
  endgenerate

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_mon_set: assert property (((evt_w & mask_w) != '0) |=>
    ((mon_r & $past(evt_w & mask_w)) == $past(evt_w & mask_w)))
    else $error("masked event did not set its monitor bit");
  chk_mon_hold: assert property ((mon_r & ~clr_w & ~{40{clr_all_w}})
    != '0 |=> ((mon_r & $past(mon_r & ~clr_w & ~{40{clr_all_w}}))
    == $past(mon_r & ~clr_w & ~{40{clr_all_w}})))
    else $error("monitor bit dropped without a clear");
  chk_mon_clr: assert property ((clr_w & ~(evt_w & mask_w)) != '0 |=>
    ((mon_r & $past(clr_w & ~(evt_w & mask_w))) == '0))
    else $error("individual clear left a monitor bit set");
  chk_clr_all: assert property (clr_all_w && (evt_w & mask_w) == '0
    |=> mon_r == '0)
    else $error("clear all left monitor bits set");
  chk_mask_rst: assert property ($past(SYS_RST) |->
    (mask_w == '0 && wd_period == 16'h0000))
    else $error("masks or watchdog not cleared by reset");
  chk_upd_copy: assert property (upd_r |=> act_r == $past(stg_r))
    else $error("update strobe did not transfer staged settings");
  chk_wd_restart: assert property (wd_restart_w |=>
    (wd_ms_r == 16'h0000 && wd_pre_r == '0) ##1 !wd_exp_r)
    else $error("watchdog did not restart from zero");
  chk_wd_pulse: assert property (wd_exp_r && !$past(wd_exp_r)
    |=> wd_pulse_r ##1 !wd_pulse_r)
    else $error("watchdog pulse width wrong");
  chk_stab_lock: assert property (SYSTEM_CLOCK_MULTIPLIER_STABLE |->
    $past(SYSTEM_CLOCK_MULTIPLIER_LOCKED) && st_ms_r >= act_r[`ICW_SLOT_STAB])
    else $error("stable without lock held for the stability time");
  chk_sys_cal: assert property (upd_r
    && stg_r[`ICW_SLOT_CTRL][`ICW_CALSYS_BIT]
    && !act_r[`ICW_SLOT_CTRL][`ICW_CALSYS_BIT] |=> SYSTEM_CLOCK_MULTIPLIER_CAL_START)
    else $error("armed calibration did not start on update");
  chk_loops_cal: assert property (LOOPS_CAL_START |->
    $past(SYSTEM_CLOCK_MULTIPLIER_STABLE) && $past(cal_r) == icw_pkg::ICW_CAL_FIRE)
    else $error("loop calibration started before clock stable");

  cov_wd_expiry: cover property (wd_exp_r ##1 wd_pulse_r);
  cov_cal_all: cover property (cal_r == icw_pkg::ICW_CAL_WAIT
    ##[1:1000] LOOPS_CAL_START);
  cov_clr_all: cover property (mon_r != '0 ##1 clr_all_w);
  cov_stable: cover property ($rose(SYSTEM_CLOCK_MULTIPLIER_STABLE));
endmodule : icw_top
